// ---- rtl/pac_ctrl.sv ----
// Power amplifier control: ASK keying, ramping, power sets, duty, tuning, cutoff
`include "pac_map.svh"
module pac_ctrl #(
  parameter int NUM_STAGES = 11,
  parameter int DIV_W = 10
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Register port
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [`PAC_ADDR_W-1:0] i_addr,
  input wire logic [`PAC_DATA_W-1:0] i_wr_data,
  output logic [`PAC_DATA_W-1:0] o_rd_data,
  // Transmission control
  input wire logic i_tx_active,
  input wire logic i_set_select,
  input wire logic i_tx_data,
  // Error events from the monitors
  input wire pac_pkg::pac_err_t i_err,
  // Amplifier drive
  output pac_pkg::pac_drive_t o_drive,
  output logic o_cutoff
);
  // Configuration registers
  logic [`PAC_DATA_W-1:0] cfg_a;
  logic [`PAC_DATA_W-1:0] cfg_b;
  logic [`PAC_DATA_W-1:0] ramp_lo;
  logic [`PAC_DATA_W-1:0] blk_en;
  logic [`PAC_DATA_W-1:0] stg_cnt;
  logic [`PAC_DATA_W-1:0] tune_duty;
  // Status flags and cutoff
  pac_pkg::pac_err_t err_flags;
  logic cutoff;
  // Synchronised inputs
  logic [1:0] data_sync;
  logic [1:0] tx_sync;
  logic [1:0] sel_sync;
  logic [2:0] err_sync0;
  logic [2:0] err_sync1;
  logic data_s;
  logic tx_s;
  logic sel_s;
  pac_pkg::pac_err_t err_s;
  // Ramp state
  logic [3:0] level;
  logic [3:0] target;
  logic [3:0] next_level;
  logic step_tick;
  logic ramping;
  // Selected setting
  logic [DIV_W-1:0] ramp_div;
  logic [2:0] sel_blocks;
  logic [3:0] sel_count;
  logic sel_ask;
  logic ramp_on;
  logic low_band;
  pac_pkg::pac_duty_t next_duty;
  logic [NUM_STAGES-1:0] next_stages;

  // Saturate a stage count to the stage total
  function automatic logic [3:0] pac_sat(input logic [3:0] cnt);
    pac_sat = (cnt > `PAC_MAX_STAGES) ? `PAC_MAX_STAGES : cnt;
  endfunction : pac_sat

  // Thermometer code of a stage count
  function automatic logic [NUM_STAGES-1:0] pac_therm(input logic [3:0] cnt);
    for (int i = 0; i < NUM_STAGES; i++)
    begin
      pac_therm[i] = (4'(i) < cnt);
    end
  endfunction : pac_therm

  // Two-stage synchronisers for pin inputs
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      data_sync <= 2'h0;
      tx_sync <= 2'h0;
      sel_sync <= 2'h0;
      err_sync0 <= 3'h0;
      err_sync1 <= 3'h0;
    end
    else
    begin
      data_sync <= {data_sync[0], i_tx_data};
      tx_sync <= {tx_sync[0], i_tx_active};
      sel_sync <= {sel_sync[0], i_set_select};
      err_sync0 <= i_err;
      err_sync1 <= err_sync0;
    end
  end

  // Only the second flop of each synchroniser feeds the logic
  assign data_s = data_sync[1];
  assign tx_s = tx_sync[1];
  assign sel_s = sel_sync[1];
  assign err_s = err_sync1;

  // Register writes; cutoff disarm bit usable any time
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      cfg_a <= `PAC_RST_CFG_A;
      cfg_b <= `PAC_RST_CFG_B;
      ramp_lo <= `PAC_RST_RAMP_LO;
      blk_en <= `PAC_RST_BLK_EN;
      stg_cnt <= `PAC_RST_STG_CNT;
      tune_duty <= `PAC_RST_TUNE_DUTY;
    end
    else if (i_wr_en)
    begin
      case (i_addr)
        `PAC_OFF_CFG_A: cfg_a <= i_wr_data;
        `PAC_OFF_CFG_B: cfg_b <= i_wr_data;
        `PAC_OFF_RAMP_LO: ramp_lo <= i_wr_data;
        `PAC_OFF_BLK_EN: blk_en <= i_wr_data;
        `PAC_OFF_STG_CNT: stg_cnt <= i_wr_data;
        `PAC_OFF_TUNE_DUTY: tune_duty <= i_wr_data;
        default: ;
      endcase
    end
  end

  // Sticky error flags, cleared by a status read; set wins
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      err_flags <= '0;
    end
    else
    begin
      if (i_rd_en && i_addr == `PAC_OFF_STATUS)
      begin
        err_flags <= err_s;
      end
      else
      begin
        err_flags <= err_flags | err_s;
      end
    end
  end

  // Read mux, registered data
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_rd_data <= 8'h00;
    end
    else if (i_rd_en)
    begin
      case (i_addr)
        `PAC_OFF_STATUS:
        begin
          o_rd_data <= `PAC_ST_FIXED;
          o_rd_data[`PAC_BIT_ST_BROWN] <= err_flags.brownout;
          o_rd_data[`PAC_BIT_ST_PAR] <= err_flags.parity;
          o_rd_data[`PAC_BIT_ST_LOCK] <= err_flags.lock;
        end
        `PAC_OFF_CFG_A: o_rd_data <= cfg_a;
        `PAC_OFF_CFG_B: o_rd_data <= cfg_b;
        `PAC_OFF_RAMP_LO: o_rd_data <= ramp_lo;
        `PAC_OFF_BLK_EN: o_rd_data <= blk_en;
        `PAC_OFF_STG_CNT: o_rd_data <= stg_cnt;
        `PAC_OFF_TUNE_DUTY: o_rd_data <= tune_duty;
        default: o_rd_data <= 8'h00;
      endcase
    end
  end

  // Cutoff latch: armed cutoff trips on any error until transmission ends or the disarm bit is set
  // Sticky flags from an unread event also trip it, so read status first
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      cutoff <= 1'b0;
    end
    else if (!cfg_a[`PAC_BIT_DISARM] && tx_s && (|err_s || |err_flags))
    begin
      cutoff <= 1'b1;
    end
    else if (!tx_s || cfg_a[`PAC_BIT_DISARM])
    begin
      cutoff <= 1'b0;
    end
  end

  // Setting selection from the transmit command
  always_comb
  begin
    ramp_div = {blk_en[`PAC_BIT_RDIV_HI:`PAC_BIT_RDIV_LO], ramp_lo};
    if (sel_s)
    begin
      sel_blocks = blk_en[`PAC_BIT_BLK2_HI:`PAC_BIT_BLK2_LO];
      sel_count = pac_sat(stg_cnt[`PAC_BIT_CNT2_HI:`PAC_BIT_CNT2_LO]);
      sel_ask = cfg_b[`PAC_BIT_KEY2];
    end
    else
    begin
      sel_blocks = blk_en[`PAC_BIT_BLK1_HI:`PAC_BIT_BLK1_LO];
      sel_count = pac_sat(stg_cnt[`PAC_BIT_CNT1_HI:`PAC_BIT_CNT1_LO]);
      sel_ask = cfg_b[`PAC_BIT_KEY1];
    end
    // Ramping applies to keyed settings only; FSK jumps
    ramp_on = cfg_b[`PAC_BIT_RAMP_EN] && sel_ask;
  end

  // Target stage level: keyed by data in ASK, held on in FSK
  always_comb
  begin
    if (!tx_s || cutoff)
    begin
      target = 4'h0;
    end
    else if (sel_ask)
    begin
      target = data_s ? sel_count : 4'h0;
    end
    else
    begin
      target = sel_count;
    end
  end

  // Timer runs only while a step is pending; otherwise it stays cleared
  assign ramping = ramp_on && (level != target) && tx_s && !cutoff;

  // Step timer for the ramp
  pac_ramp_timer #(
    .DIV_W(DIV_W)
  ) u_timer (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_run(ramping),
    .i_divider(ramp_div),
    .o_tick(step_tick)
  );

  // Next stage level: one step per tick when ramping, else jump
  always_comb
  begin
    next_level = level;
    if (!ramp_on || !tx_s || cutoff)
    begin
      next_level = target;
    end
    else if (step_tick && level < target)
    begin
      next_level = level + 4'h1;
    end
    else if (step_tick && level > target)
    begin
      next_level = level - 4'h1;
    end
  end

  // Active stage level
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      level <= 4'h0;
    end
    else
    begin
      level <= next_level;
    end
  end

  // Duty selection
  always_comb
  begin
    low_band = (cfg_a[`PAC_BIT_BAND_HI:`PAC_BIT_BAND_LO] == 2'h0);
    if (low_band)
    begin
      next_duty = pac_pkg::PAC_DUTY_33;
    end
    else if (tune_duty[`PAC_BIT_DUTY_OFF])
    begin
      next_duty = pac_pkg::PAC_DUTY_50;
    end
    else
    begin
      case (tune_duty[`PAC_BIT_DUTY_HI:`PAC_BIT_DUTY_LO])
        2'h0: next_duty = pac_pkg::PAC_DUTY_43;
        2'h1: next_duty = pac_pkg::PAC_DUTY_39;
        2'h2: next_duty = pac_pkg::PAC_DUTY_35;
        2'h3: next_duty = pac_pkg::PAC_DUTY_31;
        default: next_duty = pac_pkg::PAC_DUTY_50;
      endcase
    end
  end

  // Next level as a thermometer, so stages switch in order
  assign next_stages = pac_therm(next_level);

  // Registered amplifier drive
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_drive <= '{stages: '0, blocks: 3'h0, tuning_caps: 4'h0, duty: pac_pkg::PAC_DUTY_50};
      o_cutoff <= 1'b0;
    end
    else
    begin
      o_drive.stages <= next_stages;
      o_drive.blocks <= (tx_s && !cutoff) ? sel_blocks : 3'h0;
      o_drive.tuning_caps <= tune_duty[`PAC_BIT_TUNE_HI:`PAC_BIT_TUNE_LO];
      o_drive.duty <= next_duty;
      o_cutoff <= cutoff;
    end
  end
endmodule : pac_ctrl

// ---- rtl/pac_map.svh ----
// Register offsets, field positions, reset values and codes of the amplifier control
`ifndef PAC_MAP_SVH
`define PAC_MAP_SVH
`define PAC_ADDR_W 8
`define PAC_DATA_W 8
`define PAC_OFF_CFG_A 8'h04
`define PAC_OFF_CFG_B 8'h05
`define PAC_OFF_STATUS 8'h01
`define PAC_OFF_RAMP_LO 8'h19
`define PAC_OFF_BLK_EN 8'h1a
`define PAC_OFF_STG_CNT 8'h1b
`define PAC_OFF_TUNE_DUTY 8'h1f
`define PAC_RST_CFG_A 8'h06
`define PAC_RST_CFG_B 8'h25
`define PAC_RST_RAMP_LO 8'h80
`define PAC_RST_BLK_EN 8'h00
`define PAC_RST_STG_CNT 8'h00
`define PAC_RST_TUNE_DUTY 8'h20
`define PAC_BIT_DISARM 4
`define PAC_BIT_BAND_HI 3
`define PAC_BIT_BAND_LO 2
`define PAC_BIT_RAMP_EN 4
`define PAC_BIT_KEY1 5
`define PAC_BIT_KEY2 6
`define PAC_BIT_DUTY_OFF 6
`define PAC_BIT_DUTY_HI 5
`define PAC_BIT_DUTY_LO 4
`define PAC_BIT_TUNE_HI 3
`define PAC_BIT_TUNE_LO 0
`define PAC_BIT_BLK2_HI 7
`define PAC_BIT_BLK2_LO 5
`define PAC_BIT_BLK1_HI 4
`define PAC_BIT_BLK1_LO 2
`define PAC_BIT_RDIV_HI 1
`define PAC_BIT_RDIV_LO 0
`define PAC_BIT_CNT2_HI 7
`define PAC_BIT_CNT2_LO 4
`define PAC_BIT_CNT1_HI 3
`define PAC_BIT_CNT1_LO 0
`define PAC_BIT_ST_BROWN 2
`define PAC_BIT_ST_PAR 1
`define PAC_BIT_ST_LOCK 0
`define PAC_ST_FIXED 8'h80
`define PAC_MAX_STAGES 4'hb
`define PAC_RDIV_ZERO 10'h000
`endif

// ---- rtl/pac_pkg.sv ----
// Types shared by the amplifier control block
package pac_pkg;
  // Duty cycle applied to the amplifier
  typedef enum logic [2:0] {
    PAC_DUTY_50,
    PAC_DUTY_43,
    PAC_DUTY_39,
    PAC_DUTY_35,
    PAC_DUTY_31,
    PAC_DUTY_33
  } pac_duty_t;

  // Error events from the monitors
  typedef struct packed {
    logic brownout;
    logic parity;
    logic lock;
  } pac_err_t;

  // Drive to the amplifier core
  typedef struct packed {
    logic [10:0] stages;
    logic [2:0] blocks;
    logic [3:0] tuning_caps;
    pac_duty_t duty;
  } pac_drive_t;
endpackage : pac_pkg

// ---- rtl/pac_ramp_timer.sv ----
// Step timer that spaces successive stage switchings
module pac_ramp_timer #(
  parameter int DIV_W = 10
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Control
  input wire logic i_run,
  input wire logic [DIV_W-1:0] i_divider,
  // Step tick
  output logic o_tick
);
  logic [DIV_W-1:0] count;

  // Count divider plus one cycles between ticks
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n || !i_run)
    begin
      count <= '0;
    end
    else if (count >= i_divider)
    begin
      count <= '0;
    end
    else
    begin
      count <= count + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  assign o_tick = i_run && (count >= i_divider);
endmodule : pac_ramp_timer

// ---- verif/pac_load.sv ----
// Antenna load model: live stage count and connected tuning capacitance
module pac_load
(
  // Drive from the amplifier control
  input wire pac_pkg::pac_drive_t i_drive,
  // Observed load state
  output logic [3:0] o_live,
  output logic [9:0] o_cap_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  // Count driven stages and add up switched capacitors
  always_comb
  begin
    o_live = 4'h0;
    for (int i = 0; i < 11; i++)
      o_live += 4'(i_drive.stages[i]);
    o_cap_ff = (i_drive.tuning_caps[0] ? 10'h03c : 10'h000)
      + (i_drive.tuning_caps[1] ? 10'h078 : 10'h000)
      + (i_drive.tuning_caps[2] ? 10'h0f0 : 10'h000)
      + (i_drive.tuning_caps[3] ? 10'h1e0 : 10'h000);
  end
endmodule : pac_load

// ---- verif/pac_ctrl_asserts.sv ----
// Port-level assertions for the amplifier control
module pac_ctrl_asserts
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Register port and transmit level
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic [7:0] o_rd_data,
  input wire logic i_tx_active,
  // Amplifier drive
  input wire pac_pkg::pac_drive_t o_drive,
  input wire logic o_cutoff
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  reset_out_a: assert property (disable iff (1'h0) !i_rst_n |=>
    o_drive.stages == 11'h000 && !o_cutoff) else $error("drive not cleared");
  stage_therm_a: assert property (((o_drive.stages + 11'h001) & o_drive.stages) == 0)
    else $error("stages not contiguous");
  cut_off_a: assert property (o_cutoff |-> o_drive.stages == 0 && o_drive.blocks == 0)
    else $error("drive on while cut off");
  status_fix_a: assert property (i_rd_en && i_addr == 8'h01 |=> o_rd_data[7])
    else $error("status top bit low");
  rd_unmap_a: assert property (i_rd_en && i_addr == 8'h02 |=> o_rd_data == 8'h00)
    else $error("unmapped read not zero");
  cnt_rd_a: assert property (i_wr_en && i_addr == 8'h1b ##1 i_rd_en && !i_wr_en
    && i_addr == 8'h1b |=> o_rd_data == $past(i_wr_data, 2)) else $error("count readback");
  div_rd_a: assert property (i_wr_en && i_addr == 8'h19 ##1 i_rd_en && !i_wr_en
    && i_addr == 8'h19 |=> o_rd_data == $past(i_wr_data, 2)) else $error("divider readback");
  cut_hold_a: assert property (o_cutoff && i_tx_active && $past(i_tx_active)
    && $past(i_tx_active, 2) && $past(i_tx_active, 3) && !i_wr_en && !$past(i_wr_en)
    && !$past(i_wr_en, 2) |=> o_cutoff) else $error("cutoff released early");
endmodule : pac_ctrl_asserts

bind pac_ctrl pac_ctrl_asserts u_asserts (.i_clock(i_clock), .i_rst_n(i_rst_n),
  .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wr_data(i_wr_data),
  .o_rd_data(o_rd_data), .i_tx_active(i_tx_active), .o_drive(o_drive), .o_cutoff(o_cutoff));

// ---- verif/pac_ctrl_tb.sv ----
// Self-checking bench for the amplifier control
module pac_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic sel; logic dat; logic [7:0] blk; logic [7:0] cnt;
    logic [3:0] n; logic [2:0] b;} pac_row_t;
  logic i_clock, i_rst_n, i_wr_en, i_rd_en, i_tx_active, i_set_select, i_tx_data, o_cutoff;
  logic [7:0] i_addr, i_wr_data, o_rd_data;
  logic [3:0] live;
  logic [9:0] cap;
  pac_pkg::pac_err_t i_err;
  pac_pkg::pac_drive_t o_drive;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  pac_row_t rows[6] = '{'{1'h0, 1'h1, 8'h1c, 8'h05, 4'h5, 3'h7},
    '{1'h0, 1'h0, 8'h1c, 8'h05, 4'h0, 3'h7}, '{1'h1, 1'h0, 8'he0, 8'hf0, 4'hb, 3'h7},
    '{1'h0, 1'h1, 8'h08, 8'h0c, 4'hb, 3'h2}, '{1'h1, 1'h0, 8'h20, 8'h3a, 4'h3, 3'h1},
    '{1'h0, 1'h1, 8'h0c, 8'hb0, 4'h0, 3'h3}};
  pac_pkg::pac_duty_t duty_exp[5] = '{pac_pkg::PAC_DUTY_43, pac_pkg::PAC_DUTY_39,
    pac_pkg::PAC_DUTY_35, pac_pkg::PAC_DUTY_31, pac_pkg::PAC_DUTY_50};
  logic [7:0] rst_addr[6] = '{8'h04, 8'h05, 8'h19, 8'h1a, 8'h1b, 8'h1f};
  logic [7:0] rst_val[6] = '{8'h06, 8'h25, 8'h80, 8'h00, 8'h00, 8'h20};

  pac_ctrl uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .i_addr(i_addr), .i_wr_data(i_wr_data), .o_rd_data(o_rd_data), .i_tx_active(i_tx_active),
    .i_set_select(i_set_select), .i_tx_data(i_tx_data), .i_err(i_err), .o_drive(o_drive),
    .o_cutoff(o_cutoff));
  pac_load u_load (.i_drive(o_drive), .o_live(live), .o_cap_ff(cap));

  task automatic stop_test();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    i_wr_en = 1'h0; // Strobe stays up only between back-to-back writes
    repeat (n) @(posedge i_clock);
    #1;
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_wr_en = 1'h1;
    i_addr = a;
    i_wr_data = d;
    @(posedge i_clock);
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_rd_en = 1'h1;
    i_addr = a;
    step(1);
    i_rd_en = 1'h0;
    step(1);
    chk(16'(o_rd_data), 16'(e));
  endtask : rd
  task automatic wait_live(input logic [3:0] n);
    repeat (60) if (live !== n) step(1);
    chk(16'(live), 16'(n));
  endtask : wait_live

  // Clock at 100 ns period
  initial
  begin
    i_clock = 1'h0;
    forever #50 i_clock = ~i_clock;
  end
  // Cycle ceiling against a hang
  always @(posedge i_clock)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      stop_test();
    end
  end
  // Main sequence
  initial
  begin
    {i_rst_n, i_rd_en, i_tx_active, i_set_select, i_tx_data} = 5'h00;
    {i_addr, i_wr_data, i_err} = 19'h00000;
    step(5);
    i_rst_n = 1'h1;
    foreach (rows[k])
    begin
      i_tx_active = 1'h0;
      wr(8'h1a, rows[k].blk);
      wr(8'h1b, rows[k].cnt);
      i_set_select = rows[k].sel;
      i_tx_data = rows[k].dat;
      step(4);
      i_tx_active = 1'h1;
      step(6);
      chk(16'(live), 16'(rows[k].n));
      if (rows[k].n != 4'h0)
        chk(16'(o_drive.blocks), 16'(rows[k].b));
    end
    for (int c = 0; c < 5; c++)
    begin
      wr(8'h1f, {1'h0, c == 4, 2'(c), 4'(c * 3)});
      step(4);
      chk(16'(o_drive.duty), 16'(duty_exp[c]));
      chk(16'(cap), 16'(c * 180));
    end
    wr(8'h04, 8'h00);
    wr(8'h1f, 8'h30); // Duty select 31% still gives 33% in the low band
    step(4);
    chk(16'(o_drive.duty), 16'(pac_pkg::PAC_DUTY_33));
    wr(8'h04, 8'h04);
    wr(8'h19, 8'h02);
    wr(8'h1a, 8'h1c);
    wr(8'h1b, 8'h04);
    wr(8'h05, 8'h35);
    i_tx_data = 1'h0;
    step(20);
    i_tx_data = 1'h1;
    wait_live(4'h1);
    for (int s = 2; s <= 4; s++)
    begin
      step(2);
      chk(16'(live), 16'(s - 1));
      step(1);
      chk(16'(live), 16'(s));
    end
    i_tx_data = 1'h0;
    wait_live(4'h3);
    step(3);
    chk(16'(live), 16'h2);
    wr(8'h05, 8'h25);
    i_tx_data = 1'h1;
    step(6);
    i_err.parity = 1'h1;
    step(1);
    i_err.parity = 1'h0;
    step(6);
    chk(16'(o_cutoff), 16'h1);
    chk(16'(live), 16'h0);
    wr(8'h04, 8'h14);
    step(6);
    chk(16'(live), 16'h4);
    i_err.lock = 1'h1;
    step(6);
    chk(16'(live), 16'h4);
    i_err.lock = 1'h0;
    step(4);
    rd(8'h01, 8'h83);
    rd(8'h01, 8'h80);
    wr(8'h04, 8'h04);
    i_err.brownout = 1'h1;
    step(1);
    i_err.brownout = 1'h0;
    step(6);
    chk(16'(o_cutoff), 16'h1);
    chk(16'(live), 16'h0);
    rd(8'h01, 8'h84);
    i_rst_n = 1'h0;
    i_tx_active = 1'h0;
    step(2);
    chk(16'(live), 16'h0);
    i_rst_n = 1'h1;
    foreach (rst_addr[k])
      rd(rst_addr[k], rst_val[k]);
    rd(8'h02, 8'h00);
    wr(8'h1b, 8'h5a);
    rd(8'h1b, 8'h5a);
    wr(8'h19, 8'h3c);
    rd(8'h19, 8'h3c);
    stop_test();
  end
endmodule : pac_ctrl_tb
